/* dv/hm_homing_assertions.sv */
// Purpose: port-level checks of the homing sequencer
// Assumes: single sys_clk domain, arst_n active low
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module hm_homing_assertions (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        arst_n,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    // sequencer
    input wire logic        stop_in,
    input wire logic        drive_en,
    input wire logic        torque_limit_en,
    input wire logic [12:0] speed_cmd,
    input wire logic        step_start,
    input wire logic [31:0] step_distance,
    input wire logic        pos_load,
    input wire logic [31:0] pos_value,
    input wire logic        homing_busy,
    input wire logic        homing_complete
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_drive_when_busy: assert property (drive_en |-> homing_busy) else $error("drive outside homing");
    a_clamp_in_bump: assert property (torque_limit_en |-> homing_busy && !homing_complete)
        else $error("clamp outside bumping");
    a_speed_nonzero: assert property (drive_en && torque_limit_en |-> speed_cmd != 13'h0)
        else $error("bumping at zero speed");
    a_load_neg_offset: assert property (pos_load |-> pos_value == 32'(-step_distance))
        else $error("load value not negated offset");
    a_step_not_done: assert property (step_start |=> !homing_complete)
        else $error("complete while offset step runs");
    a_start_clears: assert property ($rose(homing_busy) |-> !homing_complete)
        else $error("complete not cleared at start");
    a_stop_abandons: assert property (homing_busy && stop_in [*3] |=> ##[0:3] !homing_busy)
        else $error("stop did not abandon homing");
endmodule
`default_nettype wire

/* dv/hm_homing_test.sv */
// Purpose: self-checking bench of the homing sequencer
// Assumes: one ms scaled down to CPM cycles
// Notes:   registers reached only over the Wishbone tasks
`timescale 1ns/1ps
`default_nettype none
`include "hm_homing_regs.svh"
module hm_homing_test;
    import hm_homing_pkg::*;
    localparam int CPM = 10;
    logic sys_clk, arst_n, cyc, stb, we, ack, irq, lim_p, lim_n, stop_in, wall, tal, sdone;
    logic den, ddir, tle, sst, pld, sreq, szd, busy, cpl;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dw, dr, q, sdist, pval;
    logic [12:0] spd;
    logic [11:0] acc, dec;
    logic [6:0] tpct;
    int fails, cmp_count, n;
    hm_homing #(.CYCLES_PER_MS(CPM)) u_hm_homing (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .irq_o(irq), .limit_pos(lim_p), .limit_neg(lim_n), .stop_in(stop_in),
        .torque_at_limit(tal), .step_done(sdone), .drive_en(den), .drive_dir(ddir), .speed_cmd(spd),
        .accel_cmd(acc), .decel_cmd(dec), .torque_limit_pct(tpct), .torque_limit_en(tle), .step_start(sst),
        .step_distance(sdist), .pos_load(pld), .pos_value(pval), .stop_req(sreq), .stop_zero_decel(szd),
        .homing_busy(busy), .homing_complete(cpl));
    hm_motor_model u_hm_motor_model (.sys_clk(sys_clk), .arst_n(arst_n), .drive_en(den), .torque_limit_en(tle),
        .step_start(sst), .wall(wall), .torque_at_limit(tal), .step_done(sdone));
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            $display("BAD %s expected %h seen %h", nm, e, s);
            fails++;
        end
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
        do
            @(posedge sys_clk);
        while (ack !== 1'b1);
        q = dr;
        {cyc, stb, we} <= 3'b000;
    endtask
    // starts homing with the given mode, over-travel enable in ctrl bit1
    task automatic go(input logic [31:0] m, input logic ot);
        bus(1'b1, `HM_ADR_MODE, m);
        bus(1'b1, `HM_ADR_CTRL, {30'h0, ot, 1'b1});
    endtask
    // waits for idle; err 0 means success expected
    task automatic settle(input logic [7:0] err);
        n = 0;
        while (busy !== 1'b0 && n < 2000)
        begin
            @(posedge sys_clk);
            n++;
        end
        bus(1'b0, `HM_ADR_STATUS, 32'h0);
        if (err != 8'h00)
            chk("err_code", err, q[7:0]);
        chk("complete", err == 8'h00, q[9]);
    endtask
    function automatic logic [31:0] mode(input logic d, input logic [3:0] t, input logic c, input logic [1:0] o);
        return {18'h0, o, 3'h0, c, t, 3'h0, d};
    endfunction
    initial
    begin
        {arst_n, cyc, stb, we, lim_p, lim_n, stop_in, wall} = 8'h00;
        {adr, sel, dw, fails, cmp_count} = {8'h00, 4'hF, 32'h0, 32'h0, 32'h0};
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        bus(1'b0, `HM_ADR_TRAVEL_MAX, 32'h0);
        chk("travel_max", 32'h7FFF_FFFF, q);
        bus(1'b0, 8'h3C, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, `HM_ADR_IRQ_EN, 32'h0000_0001);
        bus(1'b1, `HM_ADR_OFFSET, 32'h0000_0005);
        go(mode(1'b0, `HM_TYPE_DATASET, 1'b0, 2'h0), 1'b0);
        settle(8'h00);
        chk("pos_value", 32'hFFFF_FFFB, pval);
        chk("irq_done", 1'b1, irq);
        bus(1'b1, `HM_ADR_IRQ_CLR, 32'h0000_001F);
        repeat (2) @(posedge sys_clk);
        chk("irq_cleared", 1'b0, irq);
        $display("test data set done");
        go(mode(1'b0, `HM_TYPE_BUMP, 1'b0, 2'h0), 1'b0);
        settle(`HM_ERR_HOMING);
        chk("alarm_stop", 1'b0, szd);
        chk("irq_masked", 1'b0, irq);
        bus(1'b1, `HM_ADR_IRQ_EN, 32'h0000_0002);
        repeat (2) @(posedge sys_clk);
        chk("irq_err", 1'b1, irq);
        bus(1'b1, `HM_ADR_IRQ_CLR, 32'h0000_001F);
        bus(1'b1, `HM_ADR_OFFSET, 32'h0000_0064);
        go(mode(1'b0, `HM_TYPE_DATASET, 1'b1, 2'h0), 1'b0);
        settle(`HM_ERR_UNDEF);
        $display("test parameter errors done");
        bus(1'b1, `HM_ADR_SPEED_HIGH, 32'd100);
        bus(1'b1, `HM_ADR_OFS_SPEED, 32'd20);
        bus(1'b1, `HM_ADR_ACCEL, 32'd50);
        bus(1'b1, `HM_ADR_DECEL, 32'd50);
        bus(1'b1, `HM_ADR_BUMP_TIME, 32'd2);
        bus(1'b1, `HM_ADR_BUMP_TORQUE, 32'd30);
        wall <= 1'b1;
        go(mode(1'b1, `HM_TYPE_BUMP, 1'b1, 2'h0), 1'b0);
        chk("bump_drive", {1'b1, 1'b1, 13'd100, 7'd30}, {tle, ddir, spd, tpct});
        chk("bump_ramp", {12'd50, 12'd50}, {acc, dec});
        n = 0;
        while (tle === 1'b1 && n < 1000)
        begin
            @(posedge sys_clk);
            n++;
        end
        // detection counts whole ms ticks, so allow up to two extra ms
        chk("bump_time", 1'b1, n >= 2 * CPM && n <= 4 * CPM + 6);
        settle(8'h00);
        chk("pos_value", 32'hFFFF_FF9C, pval);
        $display("test bumping done");
        lim_n <= 1'b1;
        go(mode(1'b0, `HM_TYPE_BUMP, 1'b0, 2'h2), 1'b1);
        settle(`HM_ERR_HOMING);
        chk("decel_stop", 1'b0, szd);
        lim_n <= 1'b0;
        wall <= 1'b0;
        go(mode(1'b0, `HM_TYPE_BUMP, 1'b0, 2'h3), 1'b1);
        repeat (6) @(posedge sys_clk);
        chk("dir_pos", 1'b0, ddir);
        lim_p <= 1'b1;
        settle(`HM_ERR_HOMING);
        chk("zero_decel", 1'b1, szd);
        lim_p <= 1'b0;
        $display("test limits done");
        go(mode(1'b0, `HM_TYPE_BUMP, 1'b0, 2'h0), 1'b0);
        repeat (5) @(posedge sys_clk);
        stop_in <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk("abort", 2'b00, {busy, cpl});
        bus(1'b0, `HM_ADR_IRQ_STAT, 32'h0);
        chk("abort_flag", 1'b1, q[`HM_IRQ_ABORT]);
        stop_in <= 1'b0;
        $display("test stop done");
        finish_test();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        finish_test();
    end
endmodule
bind hm_homing hm_homing_assertions u_hm_homing_assertions (.sys_clk(sys_clk), .arst_n(arst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .stop_in(stop_in), .drive_en(drive_en),
    .torque_limit_en(torque_limit_en), .speed_cmd(speed_cmd), .step_start(step_start),
    .step_distance(step_distance), .pos_load(pos_load), .pos_value(pos_value), .homing_busy(homing_busy),
    .homing_complete(homing_complete));
`default_nettype wire

/* dv/hm_motor_model.sv */
// Purpose: motor and position loop seen by the sequencer
// Assumes: wall set by the bench means the axis is blocked
// Notes:   offset step takes a few cycles so completion must wait for it
`timescale 1ns/1ps
`default_nettype none
module hm_motor_model (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // commands
    input  wire logic drive_en,
    input  wire logic torque_limit_en,
    input  wire logic step_start,
    input  wire logic wall,
    // feedback
    output logic      torque_at_limit,
    output logic      step_done
);
    logic [2:0] cnt_q;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= 3'h0;
            torque_at_limit <= 1'b0;
            step_done <= 1'b0;
        end
        else
        begin
            // torque saturates only when pushing against the wall
            torque_at_limit <= drive_en & torque_limit_en & wall;
            cnt_q <= step_start ? 3'h5 : (cnt_q != 3'h0 ? cnt_q - 3'h1 : 3'h0);
            step_done <= (cnt_q == 3'h1);
        end
    end
endmodule
`default_nettype wire

/* rtl/hm_homing.sv */
// Purpose: homing sequencer: bumping and data-set homing with home offset phase
// Assumes: motor loop signals on sys_clk; limit sensors and stop input are asynchronous pins
// Notes:   settings reach the block over a classic Wishbone slave
//
// What this block does
// - bumping drives homing direction at high speed
// - torque clamped to bump limit while bumping
// - home declared after clamp held detection time
// - type code six selects bumping homing
// - direction zero positive, one negative
// - zero speed, accel or decel trips 68
// - limit active at start trips 68
// - travel-direction limit during bumping trips 68
// - stop method from over-travel setting
// - type seven: current position becomes home
// - data-set checks accel/decel only with offset
// - signed home offset, zero means none
// - complete type zero: load negated offset
// - complete type one: preset, then offset step
// - zero offset speed/accel/decel trips 69
// - negated offset beyond travel range trips 72
// - accel and decel bounded in speed terms
// - stop request abandons homing sequence
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hm_homing_regs.svh"

module hm_homing
    import hm_homing_pkg::*;
#(
    parameter int CYCLES_PER_MS = `HM_CYCLES_PER_MS
)(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // interrupt
    output logic             irq_o,
    // sensors and stop pins
    input  wire logic        limit_pos,
    input  wire logic        limit_neg,
    input  wire logic        stop_in,
    // position loop feedback
    input  wire logic        torque_at_limit,
    input  wire logic        step_done,
    // position loop commands
    output logic             drive_en,
    output logic             drive_dir,
    output logic      [12:0] speed_cmd,
    output logic      [11:0] accel_cmd,
    output logic      [11:0] decel_cmd,
    output logic      [6:0]  torque_limit_pct,
    output logic             torque_limit_en,
    output logic             step_start,
    output logic      [31:0] step_distance,
    output logic             pos_load,
    output logic      [31:0] pos_value,
    output logic             stop_req,
    output logic             stop_zero_decel,
    output logic             homing_busy,
    output logic             homing_complete
);

    localparam logic [17:0] TICK_LAST = 18'(CYCLES_PER_MS - 1);

    hm_state_vec_type s_q;
    hm_state_vec_type s_d;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic        wr;
    logic        rd;
    logic [31:0] w;
    logic        start;
    logic        lim_p;
    logic        lim_n;
    logic        lim_dir;
    logic [31:0] neg_ofs;
    logic [4:0]  ev;
    logic [4:0]  clr;

    always_comb
    begin
        s_d             = s_q;
        wr              = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
        rd              = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;
        w               = `HM_RST_ZERO;
        start           = 1'b0;
        ev              = 5'h00;
        clr             = 5'h00;
        s_d.step_start  = 1'b0;
        s_d.pos_load    = 1'b0;
        s_d.stop_req    = 1'b0;
        s_d.tick        = 1'b0;

        // three-stage synchronisers; only the second stage is used below
        s_d.lim_p_s = {s_q.lim_p_s[1:0], limit_pos};
        s_d.lim_n_s = {s_q.lim_n_s[1:0], limit_neg};
        s_d.stop_s  = {s_q.stop_s[1:0], stop_in};
        lim_p       = s_q.lim_p_s[1];
        lim_n       = s_q.lim_n_s[1];
        lim_dir     = s_q.dir ? lim_n : lim_p;
        neg_ofs     = 32'(-s_q.offset);

        // millisecond enable for the detection timer
        if (s_q.tick_cnt == TICK_LAST)
        begin
            s_d.tick_cnt = 18'h00000;
            s_d.tick     = 1'b1;
        end
        else
        begin
            s_d.tick_cnt = s_q.tick_cnt + 18'h00001;
        end

        // register bus: answers every access in the cycle after it is seen
        s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
        if (wr)
        begin
            unique case (wb_adr_i)
                `HM_ADR_CTRL:
                begin
                    w         = merge({30'h0, s_q.ot_en, 1'b0}, wb_dat_i, wb_sel_i);
                    s_d.ot_en = w[`HM_CTRL_OT_EN];
                    start     = w[`HM_CTRL_START];
                end
                `HM_ADR_SPEED_HIGH:
                begin
                    w            = merge({19'h0, s_q.spd_high}, wb_dat_i, wb_sel_i);
                    s_d.spd_high = w[12:0];
                end
                `HM_ADR_OFS_SPEED:
                begin
                    w           = merge({19'h0, s_q.spd_ofs}, wb_dat_i, wb_sel_i);
                    s_d.spd_ofs = w[12:0];
                end
                `HM_ADR_ACCEL:
                begin
                    w         = merge({20'h0, s_q.accel}, wb_dat_i, wb_sel_i);
                    s_d.accel = w[11:0];
                end
                `HM_ADR_DECEL:
                begin
                    w         = merge({20'h0, s_q.decel}, wb_dat_i, wb_sel_i);
                    s_d.decel = w[11:0];
                end
                `HM_ADR_MODE:
                begin
                    w             = merge({18'h0, s_q.ot_method, 3'h0, s_q.cpl_type, s_q.htype, 3'h0, s_q.dir},
                                          wb_dat_i, wb_sel_i);
                    s_d.dir       = w[`HM_MODE_DIR];
                    s_d.htype     = w[`HM_MODE_TYPE_MSB:`HM_MODE_TYPE_LSB];
                    s_d.cpl_type  = w[`HM_MODE_CPL];
                    s_d.ot_method = w[`HM_MODE_OTM_MSB:`HM_MODE_OTM_LSB];
                end
                `HM_ADR_BUMP_TIME:
                begin
                    w             = merge({18'h0, s_q.bump_time}, wb_dat_i, wb_sel_i);
                    s_d.bump_time = w[13:0];
                end
                `HM_ADR_BUMP_TORQUE:
                begin
                    w               = merge({25'h0, s_q.bump_torque}, wb_dat_i, wb_sel_i);
                    s_d.bump_torque = w[6:0];
                end
                `HM_ADR_OFFSET:     s_d.offset     = merge(s_q.offset, wb_dat_i, wb_sel_i);
                `HM_ADR_TRAVEL_MAX: s_d.travel_max = merge(s_q.travel_max, wb_dat_i, wb_sel_i);
                `HM_ADR_IRQ_CLR:
                begin
                    w   = merge(`HM_RST_ZERO, wb_dat_i, wb_sel_i);
                    clr = w[4:0];
                end
                `HM_ADR_IRQ_EN:
                begin
                    w          = merge({27'h0, s_q.irq_en}, wb_dat_i, wb_sel_i);
                    s_d.irq_en = w[4:0];
                end
                default:
                begin
                    w = `HM_RST_ZERO;
                end
            endcase
        end
        if (rd)
        begin
            unique case (wb_adr_i)
                `HM_ADR_CTRL:        s_d.dat = {30'h0, s_q.ot_en, 1'b0};
                `HM_ADR_SPEED_HIGH:  s_d.dat = {19'h0, s_q.spd_high};
                `HM_ADR_OFS_SPEED:   s_d.dat = {19'h0, s_q.spd_ofs};
                `HM_ADR_ACCEL:       s_d.dat = {20'h0, s_q.accel};
                `HM_ADR_DECEL:       s_d.dat = {20'h0, s_q.decel};
                `HM_ADR_MODE:        s_d.dat = {18'h0, s_q.ot_method, 3'h0, s_q.cpl_type, s_q.htype, 3'h0, s_q.dir};
                `HM_ADR_BUMP_TIME:   s_d.dat = {18'h0, s_q.bump_time};
                `HM_ADR_BUMP_TORQUE: s_d.dat = {25'h0, s_q.bump_torque};
                `HM_ADR_OFFSET:      s_d.dat = s_q.offset;
                `HM_ADR_TRAVEL_MAX:  s_d.dat = s_q.travel_max;
                `HM_ADR_STATUS:      s_d.dat = {20'h0, s_q.st, s_q.complete, s_q.st != HM_IDLE, s_q.err_code};
                `HM_ADR_IRQ_STAT:    s_d.dat = {27'h0, s_q.irq_stat};
                `HM_ADR_IRQ_EN:      s_d.dat = {27'h0, s_q.irq_en};
                default:             s_d.dat = `HM_RST_ZERO;
            endcase
        end

        // sequencer
        case (s_q.st)
            HM_IDLE:
            begin
                if (start)
                begin
                    s_d.complete = 1'b0;
                    s_d.err_code = 8'h00;
                    s_d.bump_cnt = 14'h0000;
                    s_d.tick_cnt = 18'h00000;
                    if (s_q.htype == `HM_TYPE_BUMP)
                    begin
                        if (s_q.spd_high == 13'h0000 || s_q.accel == 12'h000 || s_q.decel == 12'h000)
                        begin
                            s_d.err_code = `HM_ERR_HOMING;
                            s_d.stop_req = 1'b1;
                            s_d.stop_zero_decel = 1'b0;
                            ev[`HM_IRQ_ERR_HOMING] = 1'b1;
                        end
                        else if (s_d.ot_en && (lim_p || lim_n))
                        begin
                            s_d.err_code = `HM_ERR_HOMING;
                            s_d.stop_req = 1'b1;
                            s_d.stop_zero_decel = s_q.ot_method[0];
                            ev[`HM_IRQ_ERR_HOMING] = 1'b1;
                        end
                        else
                        begin
                            s_d.drive_en = 1'b1;
                            s_d.st       = HM_BUMP;
                        end
                    end
                    else if (s_q.htype == `HM_TYPE_DATASET)
                    begin
                        s_d.st = HM_HOME;
                    end
                    else
                    begin
                        // methods this block does not carry are refused as undefined data
                        s_d.err_code = `HM_ERR_UNDEF;
                        s_d.stop_req = 1'b1;
                        s_d.stop_zero_decel = 1'b0;
                        ev[`HM_IRQ_ERR_UNDEF] = 1'b1;
                    end
                end
            end
            HM_BUMP:
            begin
                if (s_q.ot_en && lim_dir)
                begin
                    s_d.err_code = `HM_ERR_HOMING;
                    s_d.stop_req = 1'b1;
                    s_d.stop_zero_decel = s_q.ot_method[0];
                    s_d.drive_en = 1'b0;
                    s_d.st       = HM_IDLE;
                    ev[`HM_IRQ_ERR_HOMING] = 1'b1;
                end
                else if (!torque_at_limit)
                begin
                    s_d.bump_cnt = 14'h0000;
                end
                else if (s_q.tick)
                begin
                    if (s_q.bump_cnt >= s_q.bump_time)
                    begin
                        s_d.drive_en = 1'b0;
                        s_d.st       = HM_HOME;
                    end
                    else
                    begin
                        s_d.bump_cnt = s_q.bump_cnt + 14'h0001;
                    end
                end
            end
            HM_HOME:
            begin
                // acceleration and deceleration only matter when an offset move follows
                if (s_q.cpl_type && (s_q.spd_ofs == 13'h0000 || s_q.accel == 12'h000 || s_q.decel == 12'h000))
                begin
                    s_d.err_code = `HM_ERR_UNDEF;
                    s_d.stop_req = 1'b1;
                    s_d.stop_zero_decel = 1'b0;
                    s_d.st       = HM_IDLE;
                    ev[`HM_IRQ_ERR_UNDEF] = 1'b1;
                end
                else if ($signed(neg_ofs) > $signed(s_q.travel_max) || $signed(neg_ofs) < -$signed(s_q.travel_max))
                begin
                    s_d.err_code = `HM_ERR_TRAVEL;
                    s_d.stop_req = 1'b1;
                    s_d.stop_zero_decel = 1'b0;
                    s_d.st       = HM_IDLE;
                    ev[`HM_IRQ_ERR_TRAVEL] = 1'b1;
                end
                else
                begin
                    s_d.pos_load  = 1'b1;
                    s_d.pos_value = neg_ofs;
                    if (s_q.cpl_type && s_q.offset != 32'h0000_0000)
                    begin
                        s_d.step_start = 1'b1;
                        s_d.st         = HM_OFFSET;
                    end
                    else
                    begin
                        s_d.complete = 1'b1;
                        s_d.st       = HM_IDLE;
                        ev[`HM_IRQ_DONE] = 1'b1;
                    end
                end
            end
            HM_OFFSET:
            begin
                if (step_done)
                begin
                    s_d.complete = 1'b1;
                    s_d.st       = HM_IDLE;
                    ev[`HM_IRQ_DONE] = 1'b1;
                end
            end
            default:
            begin
                s_d.st = HM_IDLE;
            end
        endcase

        // a stop request wins over any progress made in the same cycle
        if (s_q.stop_s[1] && s_q.st != HM_IDLE)
        begin
            s_d.st         = HM_IDLE;
            s_d.drive_en   = 1'b0;
            s_d.step_start = 1'b0;
            s_d.pos_load   = 1'b0;
            s_d.complete   = 1'b0;
            ev             = 5'h00;
            ev[`HM_IRQ_ABORT] = 1'b1;
        end
        s_d.busy    = s_d.st != HM_IDLE;
        s_d.clamp   = s_d.st == HM_BUMP;
        s_d.spd_cmd = (s_d.st == HM_OFFSET) ? s_d.spd_ofs : s_d.spd_high;

        // a new event wins over a clear in the same cycle
        s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
        s_d.irq      = |(s_d.irq_stat & s_d.irq_en);
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q            <= '0;
            s_q.st         <= HM_IDLE;
            s_q.travel_max <= `HM_RST_TRAVEL_MAX;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o         = s_q.dat;
    assign wb_ack_o         = s_q.ack;
    assign irq_o            = s_q.irq;
    assign drive_en         = s_q.drive_en;
    assign drive_dir        = s_q.dir;
    assign speed_cmd        = s_q.spd_cmd;
    assign accel_cmd        = s_q.accel;
    assign decel_cmd        = s_q.decel;
    assign torque_limit_pct = s_q.bump_torque;
    assign torque_limit_en  = s_q.clamp;
    assign step_start       = s_q.step_start;
    assign step_distance    = s_q.offset;
    assign pos_load         = s_q.pos_load;
    assign pos_value        = s_q.pos_value;
    assign stop_req         = s_q.stop_req;
    assign stop_zero_decel  = s_q.stop_zero_decel;
    assign homing_busy      = s_q.busy;
    assign homing_complete  = s_q.complete;

endmodule

`default_nettype wire

/* rtl/hm_homing_pkg.sv */
// Purpose: types of the homing sequencer
// Assumes: widths follow the documented setting ranges
// Notes:   numbers live in hm_homing_regs.svh
`include "hm_homing_regs.svh"

package hm_homing_pkg;

    typedef enum logic [1:0] {HM_IDLE, HM_BUMP, HM_HOME, HM_OFFSET} hm_state_type;

    typedef struct packed {
        hm_state_type st;
        logic [2:0]   lim_p_s;
        logic [2:0]   lim_n_s;
        logic [2:0]   stop_s;
        logic         ack;
        logic [31:0]  dat;
        logic         ot_en;
        logic [12:0]  spd_high;
        logic [12:0]  spd_ofs;
        logic [11:0]  accel;
        logic [11:0]  decel;
        logic         dir;
        logic [3:0]   htype;
        logic         cpl_type;
        logic [1:0]   ot_method;
        logic [13:0]  bump_time;
        logic [6:0]   bump_torque;
        logic [31:0]  offset;
        logic [31:0]  travel_max;
        logic [7:0]   err_code;
        logic         complete;
        logic [4:0]   irq_stat;
        logic [4:0]   irq_en;
        logic         irq;
        logic [17:0]  tick_cnt;
        logic         tick;
        logic [13:0]  bump_cnt;
        logic         drive_en;
        logic         step_start;
        logic         pos_load;
        logic [31:0]  pos_value;
        logic         stop_req;
        logic         stop_zero_decel;
        logic         busy;
        logic         clamp;
        logic [12:0]  spd_cmd;
    } hm_state_vec_type;

endpackage

/* rtl/hm_homing_regs.svh */
// Purpose: register offsets, field positions, reset values and timing counts of the homing sequencer
// Assumes: 32-bit classic Wishbone slave, byte addresses, one aligned word per register
// Notes:   included by the package and the sequencer
`ifndef HM_HOMING_REGS_SVH
`define HM_HOMING_REGS_SVH

`define HM_ADR_CTRL        8'h00
`define HM_ADR_SPEED_HIGH  8'h04
`define HM_ADR_OFS_SPEED   8'h08
`define HM_ADR_ACCEL       8'h0C
`define HM_ADR_DECEL       8'h10
`define HM_ADR_MODE        8'h14
`define HM_ADR_BUMP_TIME   8'h18
`define HM_ADR_BUMP_TORQUE 8'h1C
`define HM_ADR_OFFSET      8'h20
`define HM_ADR_STATUS      8'h24
`define HM_ADR_IRQ_STAT    8'h28
`define HM_ADR_IRQ_CLR     8'h2C
`define HM_ADR_IRQ_EN      8'h30
`define HM_ADR_TRAVEL_MAX  8'h34

`define HM_CTRL_START      0
`define HM_CTRL_OT_EN      1
`define HM_MODE_DIR        0
`define HM_MODE_TYPE_LSB   4
`define HM_MODE_TYPE_MSB   7
`define HM_MODE_CPL        8
`define HM_MODE_OTM_LSB    12
`define HM_MODE_OTM_MSB    13

`define HM_TYPE_BUMP       4'h6
`define HM_TYPE_DATASET    4'h7
`define HM_ERR_HOMING      8'h44
`define HM_ERR_UNDEF       8'h45
`define HM_ERR_TRAVEL      8'h48

`define HM_IRQ_DONE        0
`define HM_IRQ_ERR_HOMING  1
`define HM_IRQ_ERR_UNDEF   2
`define HM_IRQ_ERR_TRAVEL  3
`define HM_IRQ_ABORT       4

`define HM_RST_ZERO        32'h0000_0000
`define HM_RST_TRAVEL_MAX  32'h7FFF_FFFF

`define HM_CLK_PERIOD_PS   4000
`define HM_MS_PS           1000000000
`define HM_CYCLES_PER_MS   (`HM_MS_PS / `HM_CLK_PERIOD_PS)

`endif
